// file: core/scsp_pkg.sv
package scsp_pkg;
    // Register byte offsets on the APB window
    localparam logic [11:0] SCSP_SLEEP_CTRL_OFS = 12'h000;
    localparam logic [11:0] SCSP_CFG_IND_OFS    = 12'h004;
    localparam logic [11:0] SCSP_PRIO2_OFS      = 12'h008;
    localparam logic [11:0] SCSP_PRIO3_OFS      = 12'h00c;
    localparam logic [11:0] SCSP_WAKE_STAT_OFS  = 12'h010;

    // Sleep control field positions
    localparam int SCSP_WAKE_ANY_BIT   = 4;
    localparam int SCSP_LP_SEL_BIT     = 2;
    localparam int SCSP_SLEEP_EXIT_BIT = 1;

    // Configuration indicator positions
    localparam int SCSP_STK_ALIGN_BIT  = 9;
    localparam int SCSP_UNALIGN_BIT    = 3;

    // Priority field positions (top and bottom bit of each stored two-bit field)
    localparam int SCSP_SVC_PRI_HI     = 31;
    localparam int SCSP_SVC_PRI_LO     = 30;
    localparam int SCSP_TICK_PRI_HI    = 31;
    localparam int SCSP_TICK_PRI_LO    = 30;
    localparam int SCSP_PEND_PRI_HI    = 23;
    localparam int SCSP_PEND_PRI_LO    = 22;

    // Stacked status word alignment flag position
    localparam int SCSP_PSW_ALIGN_BIT  = 9;

    // Status word fields and bus qualifiers
    localparam int          SCSP_STAT_LATCH_BIT = 0;
    localparam int          SCSP_STAT_STATE_HI  = 2;
    localparam int          SCSP_STAT_STATE_LO  = 1;
    localparam logic [3:0]  SCSP_STRB_FULL      = 4'hf;
    localparam logic [1:0]  SCSP_WORD_ALIGN     = 2'h0;

    localparam logic [1:0]  SCSP_PRI_RESET  = 2'h0;
    localparam logic [31:0] SCSP_ZERO_WORD  = 32'h0000_0000;

    typedef enum logic [1:0] {
        SCSP_RUN   = 2'b00,
        SCSP_WAIT  = 2'b01,
        SCSP_SLEEP = 2'b11
    } scsp_state_t;
endpackage

// file: core/scsp_regs.sv
`timescale 1ns/10ps
// Contract
// - With wake_on_any_pending 0, only enabled interrupts or events wake the core.
// - With wake_on_any_pending 1, enabled events and all interrupts wake the core.
// - A new pending event wakes a waiting core, else is latched for next wait.
// - A send-event instruction also wakes a core waiting for an event.
// - Bit 2 selects ordinary or deep sleep; deep sleep unsupported here.
// - sleep_after_handler 1 sleeps on handler return to thread; 0 continues.
// - Configuration indicators are read-only; writes change nothing.
// - Stack alignment indicator bit 9 always reads one.
// - Alignment adjustment is recorded in stacked status bit 9 and restored on return.
// - Unaligned trap indicator bit 3 reads one; unaligned accesses raise hard fault.
// - Each configurable system handler has priority 0 through 3.
// - Priority fields are 8 bits; only bits 7:6 stored, rest read zero.
// - Second priority register holds supervisor call priority in bits 31:24.
// - Third priority register holds system tick priority in bits 31:24.
// - Third priority register holds pended service priority in bits 23:16.
module scsp_regs
    import scsp_pkg::*;
#(
    parameter int IRQ_N = 32
) (
    input  wire logic              i_sys_clk,
    input  wire logic              i_rst,
    input  wire logic              i_psel,
    input  wire logic              i_penable,
    input  wire logic              i_pwrite,
    input  wire logic [11:0]       i_paddr,
    input  wire logic [31:0]       i_pwdata,
    input  wire logic [3:0]        i_pstrb,
    output logic      [31:0]       o_prdata,
    output logic                   o_pready,
    output logic                   o_pslverr,
    input  wire logic [IRQ_N-1:0]  i_irq_pending,
    input  wire logic [IRQ_N-1:0]  i_irq_enable,
    input  wire logic              i_event,
    input  wire logic              i_send_event_instruction,
    input  wire logic              i_wait_for_event,
    input  wire logic              i_sleep_request,
    input  wire logic              i_handler_return_thread,
    input  wire logic              i_exc_entry,
    input  wire logic              i_exc_return,
    input  wire logic              i_sp_misaligned,
    input  wire logic              i_stacked_align,
    input  wire logic              i_unaligned_access,
    output logic                   o_wakeup,
    output logic                   o_sleeping,
    output logic                   o_deep_sleep,
    output logic                   o_stacked_align,
    output logic                   o_restore_align,
    output logic                   o_hard_fault_a,
    output logic [1:0]             o_supervisor_call_priority,
    output logic [1:0]             o_pended_service_priority,
    output logic [1:0]             o_system_tick_priority
);
    // Wake logic reduces at most one word of interrupt lines
    if (IRQ_N < 1 || IRQ_N > 32) begin : g_bad_irq_n
        $error("IRQ_N out of range");
    end

    logic              wake_on_any_pending;
    logic              low_power_select;
    logic              sleep_after_handler;
    logic              event_latched;
    logic [IRQ_N-1:0]  pend_prev;
    scsp_state_t       state;
    scsp_state_t       next_state;
    logic              setup;
    logic              wr;
    logic              rd;
    logic              hit;
    logic              aligned;
    logic              full_word;
    logic [IRQ_N-1:0]  new_pend;
    logic              any_new_pend;
    logic              enabled_new_pend;
    logic              wake_src;
    logic              wake_any;
    logic              leaving;
    logic [31:0]       next_rdata;

    // Matches any mapped register offset; shared by the write and read strobes
    function automatic logic addr_hit(input logic [11:0] a);
        logic r;
        r = 1'b0;
        case (a)
            SCSP_SLEEP_CTRL_OFS: r = 1'b1;
            SCSP_CFG_IND_OFS:    r = 1'b1;
            SCSP_PRIO2_OFS:      r = 1'b1;
            SCSP_PRIO3_OFS:      r = 1'b1;
            SCSP_WAKE_STAT_OFS:  r = 1'b1;
            default:             r = 1'b0;
        endcase
        return r;
    endfunction

    // Write strobe for one register offset
    function automatic logic reg_write(input logic w, input logic [11:0] a,
                                       input logic [11:0] ofs);
        return w && a == ofs;
    endfunction

    // Full-word writes only; partial strobes are refused as an error
    assign setup     = i_psel && !i_penable;
    assign aligned   = i_paddr[1:0] == SCSP_WORD_ALIGN;
    assign full_word = i_pstrb == SCSP_STRB_FULL;
    assign hit       = addr_hit(i_paddr) && aligned;
    assign wr        = setup && i_pwrite && hit && full_word;
    assign rd        = setup && !i_pwrite && hit;

    // Rising pending edges; masked unless any-pending wake is enabled
    assign new_pend         = i_irq_pending & ~pend_prev;
    assign any_new_pend     = |new_pend;
    assign enabled_new_pend = |(new_pend & i_irq_enable);

    always_comb begin
        if (wake_on_any_pending) begin
            wake_any = any_new_pend;
        end else begin
            wake_any = enabled_new_pend;
        end
        wake_src = wake_any || i_event;
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            pend_prev <= '0;
        end else begin
            pend_prev <= i_irq_pending;
        end
    end

    // Sleep control register; reserved bits not stored
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            wake_on_any_pending <= 1'b0;
        end else if (reg_write(wr, i_paddr, SCSP_SLEEP_CTRL_OFS)) begin
            wake_on_any_pending <= i_pwdata[SCSP_WAKE_ANY_BIT];
        end
    end

    // Read back and reflected on o_deep_sleep during sleep; software must leave it clear
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            low_power_select <= 1'b0;
        end else if (reg_write(wr, i_paddr, SCSP_SLEEP_CTRL_OFS)) begin
            low_power_select <= i_pwdata[SCSP_LP_SEL_BIT];
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            sleep_after_handler <= 1'b0;
        end else if (reg_write(wr, i_paddr, SCSP_SLEEP_CTRL_OFS)) begin
            sleep_after_handler <= i_pwdata[SCSP_SLEEP_EXIT_BIT];
        end
    end

    // Priority fields: two stored bits each, the low six never kept
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_supervisor_call_priority <= SCSP_PRI_RESET;
        end else if (reg_write(wr, i_paddr, SCSP_PRIO2_OFS)) begin
            o_supervisor_call_priority <= i_pwdata[SCSP_SVC_PRI_HI:SCSP_SVC_PRI_LO];
        end
    end

    // Third register holds two fields written together
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_system_tick_priority <= SCSP_PRI_RESET;
        end else if (reg_write(wr, i_paddr, SCSP_PRIO3_OFS)) begin
            o_system_tick_priority <= i_pwdata[SCSP_TICK_PRI_HI:SCSP_TICK_PRI_LO];
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_pended_service_priority <= SCSP_PRI_RESET;
        end else if (reg_write(wr, i_paddr, SCSP_PRIO3_OFS)) begin
            o_pended_service_priority <= i_pwdata[SCSP_PEND_PRI_HI:SCSP_PEND_PRI_LO];
        end
    end

    // Event latch: a new event wins over the consuming wait
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            event_latched <= 1'b0;
        end else if (wake_src || i_send_event_instruction) begin
            event_latched <= state != SCSP_WAIT;
        end else if (i_wait_for_event && state == SCSP_RUN) begin
            event_latched <= 1'b0;
        end
    end

    always_comb begin
        next_state = state;
        unique case (state)
            SCSP_RUN: begin
                if (i_wait_for_event && !event_latched && !wake_src &&
                    !i_send_event_instruction) begin
                    next_state = SCSP_WAIT;
                end else if (i_sleep_request ||
                             (i_handler_return_thread && sleep_after_handler)) begin
                    next_state = SCSP_SLEEP;
                end
            end
            SCSP_WAIT: begin
                if (wake_src || i_send_event_instruction) begin
                    next_state = SCSP_RUN;
                end
            end
            SCSP_SLEEP: begin
                if (wake_src) begin
                    next_state = SCSP_RUN;
                end
            end
            // The spare code is unreachable; fall back to running if it appears
            default: begin
                next_state = SCSP_RUN;
            end
        endcase
    end

    assign leaving = state != SCSP_RUN && next_state == SCSP_RUN;

    // State codes step by one bit from running to waiting to sleeping
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            state <= SCSP_RUN;
        end else begin
            state <= next_state;
        end
    end

    // Wake pulse lasts one cycle, launched with the move back to running
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_wakeup <= 1'b0;
        end else begin
            o_wakeup <= leaving;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_sleeping <= 1'b0;
        end else begin
            o_sleeping <= next_state != SCSP_RUN;
        end
    end

    // Deep sleep is unsupported; the request is only reflected, never acted upon
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_deep_sleep <= 1'b0;
        end else begin
            o_deep_sleep <= next_state == SCSP_SLEEP && low_power_select;
        end
    end

    // Stack alignment tracking and unaligned trap
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_stacked_align <= 1'b0;
        end else if (i_exc_entry) begin
            o_stacked_align <= i_sp_misaligned;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_restore_align <= 1'b0;
        end else begin
            o_restore_align <= i_exc_return && i_stacked_align;
        end
    end

    // Every unaligned access traps; no mode lets one through
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_hard_fault_a <= 1'b0;
        end else begin
            o_hard_fault_a <= i_unaligned_access;
        end
    end

    // Read mux; unmapped words read zero
    always_comb begin
        next_rdata = SCSP_ZERO_WORD;
        unique case (i_paddr)
            SCSP_SLEEP_CTRL_OFS: begin
                next_rdata[SCSP_WAKE_ANY_BIT]   = wake_on_any_pending;
                next_rdata[SCSP_LP_SEL_BIT]     = low_power_select;
                next_rdata[SCSP_SLEEP_EXIT_BIT] = sleep_after_handler;
            end
            SCSP_CFG_IND_OFS: begin
                next_rdata[SCSP_STK_ALIGN_BIT] = 1'b1;
                next_rdata[SCSP_UNALIGN_BIT]   = 1'b1;
            end
            SCSP_PRIO2_OFS: begin
                next_rdata[SCSP_SVC_PRI_HI:SCSP_SVC_PRI_LO] = o_supervisor_call_priority;
            end
            SCSP_PRIO3_OFS: begin
                next_rdata[SCSP_TICK_PRI_HI:SCSP_TICK_PRI_LO] = o_system_tick_priority;
                next_rdata[SCSP_PEND_PRI_HI:SCSP_PEND_PRI_LO] = o_pended_service_priority;
            end
            SCSP_WAKE_STAT_OFS: begin
                next_rdata[SCSP_STAT_LATCH_BIT]                   = event_latched;
                next_rdata[SCSP_STAT_STATE_HI:SCSP_STAT_STATE_LO] = state;
            end
            default: begin
                next_rdata = SCSP_ZERO_WORD;
            end
        endcase
    end

    // No wait states: answer registered in the setup cycle, so reads see a settled mux
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_pready <= 1'b0;
        end else begin
            o_pready <= setup;
        end
    end

    // Refused: unmapped or unaligned access, or a partial-strobe write
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_pslverr <= 1'b0;
        end else begin
            o_pslverr <= setup && !(wr || rd);
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_prdata <= SCSP_ZERO_WORD;
        end else begin
            o_prdata <= rd ? next_rdata : SCSP_ZERO_WORD;
        end
    end
endmodule

// file: bench/scsp_regs_sva.sv
`timescale 1ns/10ps
module scsp_regs_chk
    import scsp_pkg::*;
#(
    parameter int IRQ_N = 32
) (
    input wire logic             i_sys_clk,
    input wire logic             i_rst,
    input wire logic             i_psel,
    input wire logic             i_penable,
    input wire logic             i_pwrite,
    input wire logic [11:0]      i_paddr,
    input wire logic [IRQ_N-1:0] i_irq_pending,
    input wire logic [IRQ_N-1:0] i_irq_enable,
    input wire logic             i_unaligned_access,
    input wire logic [31:0]      o_prdata,
    input wire logic             o_pready,
    input wire logic             o_wakeup,
    input wire logic             o_sleeping,
    input wire logic             o_hard_fault_a,
    input wire logic [1:0]       o_supervisor_call_priority
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    logic rd_ans;
    logic wr_prio2;
    // Address is still held by the master in the answer cycle
    assign rd_ans = o_pready && i_psel && !i_pwrite;
    assign wr_prio2 = i_psel && i_pwrite && i_paddr == SCSP_PRIO2_OFS;
    a_ready_after_setup: assert property (i_psel && !i_penable |=> o_pready)
        else $error("ready missing after setup");
    a_cfg_constant: assert property (rd_ans && i_paddr == SCSP_CFG_IND_OFS
        |-> o_prdata == 32'h0000_0208) else $error("config word wrong");
    a_sleep_rsvd: assert property (rd_ans && i_paddr == SCSP_SLEEP_CTRL_OFS
        |-> (o_prdata & 32'hffff_ffe9) == 32'h0) else $error("reserved bits set");
    a_prio2_field: assert property (rd_ans && i_paddr == SCSP_PRIO2_OFS
        |-> o_prdata == {o_supervisor_call_priority, 30'h0}) else $error("prio2 read wrong");
    a_prio_held: assert property ($changed(o_supervisor_call_priority)
        |-> $past(wr_prio2)) else $error("priority changed without write");
    a_fault_after: assert property (i_unaligned_access |=> o_hard_fault_a)
        else $error("no fault after unaligned access");
    a_wake_ends: assert property (o_wakeup |-> !o_sleeping && $past(o_sleeping))
        else $error("wake pulse without leaving sleep");
    a_irq_wakes: assert property (o_sleeping
        && |(i_irq_pending & i_irq_enable & ~$past(i_irq_pending)) |-> ##[0:3] o_wakeup)
        else $error("enabled interrupt did not wake");
endmodule

bind scsp_regs scsp_regs_chk #(.IRQ_N(IRQ_N)) chk_u (.i_sys_clk, .i_rst, .i_psel, .i_penable,
    .i_pwrite, .i_paddr, .i_irq_pending, .i_irq_enable, .i_unaligned_access, .o_prdata,
    .o_pready, .o_wakeup, .o_sleeping, .o_hard_fault_a, .o_supervisor_call_priority);

// file: bench/scsp_core_model.sv
`timescale 1ns/10ps
module scsp_core_model #(
    parameter int IRQ_N = 32
) (
    input  wire logic             i_sys_clk,
    output logic      [IRQ_N-1:0] o_irq_pending,
    output logic      [IRQ_N-1:0] o_irq_enable,
    output logic      [7:0]       o_pulse,
    output logic                  o_misaligned
);
    initial begin
        o_irq_pending = '0;
        o_irq_enable = '0;
        o_pulse = 8'h00;
        o_misaligned = 1'b0;
    end
    // Core strobes last exactly one cycle, never two back to back
    task automatic fire(input int k);
        @(posedge i_sys_clk);
        o_pulse <= 8'h01 << k;
        @(posedge i_sys_clk);
        o_pulse <= 8'h00;
    endtask
    task automatic lv(input logic [IRQ_N-1:0] p, input logic [IRQ_N-1:0] e, input logic m);
        @(posedge i_sys_clk);
        o_irq_pending <= p;
        o_irq_enable <= e;
        o_misaligned <= m;
    endtask
endmodule

// file: bench/tb_scsp_regs.sv
`timescale 1ns/10ps
module tb_scsp_regs
    import scsp_pkg::*;
;
    logic        i_sys_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'h0;
    wire  [31:0] prdata, irq_p, irq_e;
    wire  [7:0]  pl;
    wire  [1:0]  svc, pend, tick;
    wire         pready, pslverr, wakeup, sleeping, stk, mis;
    wire         deep, rest, hf;
    int          num_errors = 0;
    int          compares = 0;
    int          cyc = 0;
    always #10 i_sys_clk = ~i_sys_clk;
    scsp_core_model core_u (.i_sys_clk, .o_irq_pending(irq_p), .o_irq_enable(irq_e),
        .o_pulse(pl), .o_misaligned(mis));
    scsp_regs dut_u (.i_sys_clk, .i_rst, .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_irq_pending(irq_p), .i_irq_enable(irq_e),
        .i_event(pl[0]), .i_send_event_instruction(pl[1]), .i_wait_for_event(pl[2]),
        .i_sleep_request(pl[3]), .i_handler_return_thread(pl[4]), .i_exc_entry(pl[5]),
        .i_exc_return(pl[6]), .i_unaligned_access(pl[7]), .i_sp_misaligned(mis),
        .i_stacked_align(mis), .o_wakeup(wakeup), .o_sleeping(sleeping), .o_deep_sleep(deep),
        .o_stacked_align(stk), .o_restore_align(rest), .o_hard_fault_a(hf),
        .o_supervisor_call_priority(svc), .o_pended_service_priority(pend),
        .o_system_tick_priority(tick));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic test_done;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Master holds the request until pready is seen at a rising edge
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        input logic [3:0] s, input logic [31:0] e, input logic er);
        @(posedge i_sys_clk);
        {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, s};
        @(posedge i_sys_clk);
        penable <= 1'b1;
        do @(posedge i_sys_clk); while (pready !== 1'b1);
        chk("pslverr", {31'h0, er}, {31'h0, pslverr});
        if (!w) chk("prdata", e, prdata);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wake(input logic e);
        logic g;
        g = 1'b0;
        repeat (6) begin
            @(negedge i_sys_clk);
            if (wakeup === 1'b1) g = 1'b1;
        end
        chk("wakeup", {31'h0, e}, {31'h0, g});
    endtask
    task automatic slp(input logic e);
        repeat (3) @(negedge i_sys_clk);
        chk("sleeping", {31'h0, e}, {31'h0, sleeping});
    endtask
    always @(posedge i_sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            test_done;
        end
    end
    initial begin
        repeat (16) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        for (int i = 0; i < 4; i++) xfer(0, 12'(i * 4), 0, 4'hf, i == 1 ? 32'h208 : 0, 0);
        xfer(1, SCSP_CFG_IND_OFS, 32'hffff_fdf7, 4'hf, 0, 0);
        xfer(0, SCSP_CFG_IND_OFS, 0, 4'hf, 32'h0000_0208, 0);
        xfer(1, SCSP_SLEEP_CTRL_OFS, 32'hffff_fffb, 4'hf, 0, 0);
        xfer(0, SCSP_SLEEP_CTRL_OFS, 0, 4'hf, 32'h0000_0012, 0);
        xfer(1, SCSP_PRIO2_OFS, 32'hffff_ffff, 4'hf, 0, 0);
        xfer(0, SCSP_PRIO2_OFS, 0, 4'hf, 32'hc000_0000, 0);
        chk("svc", 32'h3, {30'h0, svc});
        for (int k = 0; k < 4; k++) begin
            xfer(1, SCSP_PRIO3_OFS, {k[1:0], 6'h3f, ~k[1:0], 22'h3fffff}, 4'hf, 0, 0);
            xfer(0, SCSP_PRIO3_OFS, 0, 4'hf, {k[1:0], 6'h0, ~k[1:0], 22'h0}, 0);
            chk("tick", {30'h0, k[1:0]}, {30'h0, tick});
            chk("pend", {30'h0, ~k[1:0]}, {30'h0, pend});
        end
        xfer(1, SCSP_PRIO2_OFS, 32'h0, 4'h1, 0, 1);
        xfer(0, SCSP_PRIO2_OFS, 0, 4'hf, 32'hc000_0000, 0);
        xfer(0, 12'h020, 0, 4'hf, 0, 1);
        xfer(0, 12'h002, 0, 4'hf, 0, 1);
        xfer(1, SCSP_SLEEP_CTRL_OFS, 32'h0, 4'hf, 0, 0);
        core_u.fire(2);
        slp(1);
        core_u.lv(32'h1, 32'h0, 1'b0);
        wake(0);
        core_u.fire(0);
        wake(1);
        core_u.lv(32'h0, 32'h0, 1'b0);
        xfer(1, SCSP_SLEEP_CTRL_OFS, 32'h10, 4'hf, 0, 0);
        core_u.fire(2);
        core_u.lv(32'h1, 32'h0, 1'b0);
        wake(1);
        core_u.lv(32'h0, 32'h0, 1'b0);
        core_u.fire(2);
        core_u.fire(1);
        wake(1);
        core_u.fire(0);
        core_u.fire(2);
        slp(0);
        xfer(1, SCSP_SLEEP_CTRL_OFS, 32'h2, 4'hf, 0, 0);
        core_u.fire(4);
        slp(1);
        core_u.lv(32'h2, 32'h2, 1'b1);
        wake(1);
        xfer(1, SCSP_SLEEP_CTRL_OFS, 32'h0, 4'hf, 0, 0);
        core_u.fire(4);
        slp(0);
        core_u.fire(3);
        slp(1);
        chk("deep", 32'h0, {31'h0, deep});
        core_u.fire(1);
        slp(1);
        core_u.fire(0);
        wake(1);
        core_u.fire(5);
        @(negedge i_sys_clk);
        chk("stacked", 32'h1, {31'h0, stk});
        core_u.fire(6);
        @(negedge i_sys_clk);
        chk("restore", 32'h1, {31'h0, rest});
        core_u.fire(7);
        @(negedge i_sys_clk);
        chk("fault", 32'h1, {31'h0, hf});
        @(negedge i_sys_clk);
        chk("fault_end", 32'h0, {31'h0, hf});
        repeat (4) @(posedge i_sys_clk);
        test_done;
    end
endmodule
